// File: apdod_map.vh
// Purpose: Constants for the axis page decoder and output gate
// Assumes: Byte addressed controller bus, 16-bit address, page register 8 bits
// Notes:   Definitions only
`ifndef APDOD_MAP_VH
`define APDOD_MAP_VH
`define APDOD_WIN_LO        16'hF400
`define APDOD_WIN_HI        16'hF7FF
`define APDOD_ADDR_W        16
`define APDOD_PAGE_W        8
`define APDOD_DPR_AW        11
`define APDOD_HALF_AW       10
`define APDOD_AXIS1         1'b0
`define APDOD_AXIS2         1'b1
`define APDOD_PAGE_STEP     8'h01
`define APDOD_DIN_PER_AXIS  4
`define APDOD_DOUT_PER_AXIS 2
`define APDOD_ABS_BITS      20
`define APDOD_CNT_W         16
`define APDOD_DIFF_KHZ      500
`define APDOD_HTL_KHZ       50
`define APDOD_CLK_KHZ       250000
`endif

// File: apdod_axis_in.v
// Purpose: One axis of encoder and digital input capture
// Assumes: All inputs asynchronous pins, two-stage synchronised here
// Notes:   Quadrature x4 counting; Gray position converted to binary
`timescale 1ns/1ps
`include "apdod_map.vh"
module apdod_axis_in #(
	parameter ABS_W = `APDOD_ABS_BITS,
	parameter CNT_W = `APDOD_CNT_W,
	parameter DIN_W = `APDOD_DIN_PER_AXIS
) (
	input  wire             clk,
	input  wire             reset_n,
	input  wire             track_a,
	input  wire             track_b,
	input  wire             ref_pulse,
	input  wire [ABS_W-1:0] gray_pos,
	input  wire [DIN_W-1:0] dig_in,
	output reg  [CNT_W-1:0] count_reg,
	output reg              ref_seen_reg,
	output reg  [ABS_W-1:0] abs_pos_reg,
	output reg  [DIN_W-1:0] dig_in_reg
);
	// Gray to binary, prefix xor from the top bit down
	function [ABS_W-1:0] gray2bin;
		input [ABS_W-1:0] g;
		integer i;
		begin
			gray2bin[ABS_W-1] = g[ABS_W-1];
			for (i = ABS_W-2; i >= 0; i = i - 1) begin
				gray2bin[i] = gray2bin[i+1] ^ g[i];
			end
		end
	endfunction

	reg [2:0]       s1_reg;
	reg [2:0]       s2_reg;
	reg [1:0]       ab_old_reg;
	reg             r_old_reg;
	reg [ABS_W-1:0] g1_reg;
	reg [ABS_W-1:0] g2_reg;
	reg [DIN_W-1:0] d1_reg;
	wire [1:0]      ab_now;
	wire            step;
	wire            up;

	assign ab_now = s2_reg[1:0];
	// One edge on either track per step; 250 MHz sampling far exceeds 500 kHz
	assign step = (ab_now[0] ^ ab_old_reg[0]) ^ (ab_now[1] ^ ab_old_reg[1]);
	assign up   = ab_now[0] ^ ab_old_reg[1];

	// Pin synchronisers; first stages feed only second stages
	always @(posedge clk) begin
		if (!reset_n) begin
			s1_reg       <= 3'h0;
			s2_reg       <= 3'h0;
			ab_old_reg   <= 2'h0;
			r_old_reg    <= 1'b0;
			g1_reg       <= {ABS_W{1'b0}};
			g2_reg       <= {ABS_W{1'b0}};
			d1_reg       <= {DIN_W{1'b0}};
			dig_in_reg   <= {DIN_W{1'b0}};
			count_reg    <= {CNT_W{1'b0}};
			ref_seen_reg <= 1'b0;
			abs_pos_reg  <= {ABS_W{1'b0}};
		end else begin
			s1_reg     <= {ref_pulse, track_b, track_a};
			s2_reg     <= s1_reg;
			ab_old_reg <= ab_now;
			r_old_reg  <= s2_reg[2];
			g1_reg     <= gray_pos;
			g2_reg     <= g1_reg;
			d1_reg     <= dig_in;
			dig_in_reg <= d1_reg;
			// Double-track skips are illegal and ignored
			if (step && up) begin
				count_reg <= count_reg + 1'b1;
			end else if (step) begin
				count_reg <= count_reg - 1'b1;
			end
			if (s2_reg[2] && !r_old_reg) begin
				ref_seen_reg <= 1'b1;
			end
			abs_pos_reg <= gray2bin(g2_reg);
		end
	end
endmodule // apdod_axis_in

// File: apdod_top.v
// Purpose: Page decode of the shared memory, output disable, axis inputs
// Assumes: Bus strobe sync to clk; switches and jumper are static pins
// Notes:   Shared memory 2 KB, two 1 KB pages, one per axis
// Functional notes
// - Shared 2 KB memory in two pages
// - Page one axis one, page two axis two
// - Respond only inside window F400 to F7FF
// - Second page is base page plus one
// - Option jumper lets disable force outputs off
// - Quadrature counting with reference, 500/50 kHz
// - Capture up to 20-bit Gray position
// - Four inputs, two outputs per axis
`timescale 1ns/1ps
`include "apdod_map.vh"
module apdod_top #(
	parameter ABS_W = `APDOD_ABS_BITS,
	parameter CNT_W = `APDOD_CNT_W
) (
	input  wire                     clk,
	input  wire                     reset_n,
	input  wire                     bus_sel,
	input  wire                     bus_we,
	input  wire [`APDOD_ADDR_W-1:0] bus_addr,
	input  wire [`APDOD_PAGE_W-1:0] bus_page,
	input  wire [7:0]               bus_wdata,
	output reg  [7:0]               bus_rdata,
	output reg                      bus_ack,
	input  wire [`APDOD_PAGE_W-1:0] page_number_switch,
	input  wire                     command_output_disable,
	input  wire                     output_disable_option_jumper,
	input  wire                     fw_we,
	input  wire [`APDOD_DPR_AW-1:0] fw_addr,
	input  wire [7:0]               fw_wdata,
	output reg  [7:0]               fw_rdata,
	input  wire [3:0]               fw_dout,
	output reg  [3:0]               dig_out,
	input  wire [1:0]               track_a,
	input  wire [1:0]               track_b,
	input  wire [1:0]               ref_pulse,
	input  wire [2*ABS_W-1:0]       gray_pos,
	input  wire [7:0]               dig_in,
	output reg  [2*CNT_W-1:0]       enc_count,
	output reg  [1:0]               ref_seen,
	output reg  [2*ABS_W-1:0]       abs_pos,
	output reg  [7:0]               dig_in_sync
);
	localparam DEPTH = 1 << `APDOD_DPR_AW;

	// Shared memory, both ports in one array
	reg [7:0] dpr_mem [0:DEPTH-1];

	reg [`APDOD_PAGE_W-1:0] sw1_reg;
	reg [`APDOD_PAGE_W-1:0] base_reg;
	reg [1:0]               dis1_reg;
	reg [1:0]               dis2_reg;
	reg                     hit;
	reg                     half;
	wire [`APDOD_PAGE_W-1:0] page2;
	wire [2*CNT_W-1:0]      cnt_w;
	wire [1:0]              ref_w;
	wire [2*ABS_W-1:0]      abs_w;
	wire [7:0]              din_w;
	wire [`APDOD_DPR_AW-1:0] mem_addr;

	// Low bit forced clear so an odd setting still yields a pair
	assign page2    = base_reg + `APDOD_PAGE_STEP;
	assign mem_addr = {half, bus_addr[`APDOD_HALF_AW-1:0]};

	// Window and page decode
	always @* begin
		hit  = 1'b0;
		half = `APDOD_AXIS1;
		if (!bus_sel || bus_addr < `APDOD_WIN_LO || bus_addr > `APDOD_WIN_HI) begin
			hit = 1'b0;
		end else if (bus_page == base_reg) begin
			hit  = 1'b1;
			half = `APDOD_AXIS1;
		end else if (bus_page == page2) begin
			hit  = 1'b1;
			half = `APDOD_AXIS2;
		end
	end

	// Switch and disable synchronisers
	always @(posedge clk) begin
		if (!reset_n) begin
			sw1_reg  <= 8'h00;
			base_reg <= 8'h00;
			dis1_reg <= 2'h0;
			dis2_reg <= 2'h0;
		end else begin
			sw1_reg  <= page_number_switch;
			base_reg <= {sw1_reg[`APDOD_PAGE_W-1:1], 1'b0};
			dis1_reg <= {output_disable_option_jumper, command_output_disable};
			dis2_reg <= dis1_reg;
		end
	end

	// Both ports in one process so the array has one driver; bus wins a same-address write
	always @(posedge clk) begin
		if (!reset_n) begin
			bus_ack   <= 1'b0;
			bus_rdata <= 8'h00;
			fw_rdata  <= 8'h00;
		end else begin
			bus_ack <= hit;
			if (hit && bus_we) begin
				dpr_mem[mem_addr] <= bus_wdata;
			end
			if (fw_we && !(hit && bus_we && mem_addr == fw_addr)) begin
				dpr_mem[fw_addr] <= fw_wdata;
			end
			// Misses get no ack and leave data at zero
			bus_rdata <= hit ? dpr_mem[mem_addr] : 8'h00;
			fw_rdata  <= dpr_mem[fw_addr];
		end
	end

	// Output gate; disable seen two clocks late, fine for relay outputs
	always @(posedge clk) begin
		if (!reset_n) begin
			dig_out <= 4'h0;
		end else if (dis2_reg[1] && dis2_reg[0]) begin
			dig_out <= 4'h0;
		end else begin
			dig_out <= fw_dout;
		end
	end

	// Registered copies of the axis captures
	always @(posedge clk) begin
		if (!reset_n) begin
			enc_count   <= {2*CNT_W{1'b0}};
			ref_seen    <= 2'h0;
			abs_pos     <= {2*ABS_W{1'b0}};
			dig_in_sync <= 8'h00;
		end else begin
			enc_count   <= cnt_w;
			ref_seen    <= ref_w;
			abs_pos     <= abs_w;
			dig_in_sync <= din_w;
		end
	end

	genvar ax;
	generate
		for (ax = 0; ax < 2; ax = ax + 1) begin : g_axis
			apdod_axis_in #(
				.ABS_W (ABS_W),
				.CNT_W (CNT_W),
				.DIN_W (`APDOD_DIN_PER_AXIS)
			) u_axis (
				.clk          (clk),
				.reset_n      (reset_n),
				.track_a      (track_a[ax]),
				.track_b      (track_b[ax]),
				.ref_pulse    (ref_pulse[ax]),
				.gray_pos     (gray_pos[ax*ABS_W +: ABS_W]),
				.dig_in       (dig_in[ax*`APDOD_DIN_PER_AXIS +: `APDOD_DIN_PER_AXIS]),
				.count_reg    (cnt_w[ax*CNT_W +: CNT_W]),
				.ref_seen_reg (ref_w[ax]),
				.abs_pos_reg  (abs_w[ax*ABS_W +: ABS_W]),
				.dig_in_reg   (din_w[ax*`APDOD_DIN_PER_AXIS +: `APDOD_DIN_PER_AXIS])
			);
		end
	endgenerate
endmodule // apdod_top

// File: apdod_ctrl_model.sv
// Purpose: Controller side model, base page switch and disable line
// Assumes: Stop request comes from the bench, in step with clk
// Notes:   Switch kept even, so base and base plus one pair up
`timescale 1ns/1ps
module apdod_ctrl_model (
	input  wire       clk,
	input  wire       stop_req,
	input  wire [6:0] page_pair,
	output reg        command_output_disable,
	output wire [7:0] page_number_switch
);
	// Installer can only set even pages 0 to 254
	assign page_number_switch = {page_pair, 1'b0};
	// Disable follows stop, launched just after the edge
	initial command_output_disable = 1'b0;
	always @(posedge clk) begin
		command_output_disable <= #1 stop_req;
	end
endmodule // apdod_ctrl_model

// File: apdod_checker.sv
// Purpose: Port checker for page decode and output gate
// Assumes: Switch static; no bus traffic before third edge after reset
// Notes:   Bound into apdod_top
`timescale 1ns/1ps
module apdod_checker (
	input wire        clk,
	input wire        reset_n,
	input wire        bus_sel,
	input wire [15:0] bus_addr,
	input wire [7:0]  bus_page,
	input wire        bus_ack,
	input wire [7:0]  bus_rdata,
	input wire [7:0]  page_number_switch,
	input wire        command_output_disable,
	input wire        output_disable_option_jumper,
	input wire [3:0]  fw_dout,
	input wire [3:0]  dig_out
);
	// Expected decode; base bit0 dropped since odd settings are cleared
	wire [7:0] base = {page_number_switch[7:1], 1'b0};
	wire sel_w = bus_sel && bus_addr >= 16'hF400 && bus_addr <= 16'hF7FF;
	wire hit = sel_w && (bus_page == base || bus_page == base + 8'h01);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	first_page_a: assert property (sel_w && bus_page == base |=> bus_ack)
		else $error("first page not acked");
	second_page_a: assert property (sel_w && bus_page == base + 8'h01 |=> bus_ack)
		else $error("second page not acked");
	window_low_a: assert property (bus_sel && bus_addr < 16'hF400 |=> !bus_ack)
		else $error("ack below window");
	window_high_a: assert property (bus_sel && bus_addr > 16'hF7FF |=> !bus_ack)
		else $error("ack above window");
	stray_page_a: assert property (sel_w && !hit |=> !bus_ack && bus_rdata == 8'h00)
		else $error("stray page answered");
	ack_cause_a: assert property (bus_ack |-> $past(hit))
		else $error("ack without hit");
	disable_gate_a: assert property ((command_output_disable &&
		output_disable_option_jumper)[*3] |=> dig_out == 4'h0) else $error("outputs not off");
	jumper_off_a: assert property ((!output_disable_option_jumper &&
		$stable(fw_dout))[*5] |-> dig_out == fw_dout) else $error("outputs not passed");
	cover property (hit ##1 hit);
	cover property (sel_w && !hit);
	cover property (command_output_disable && output_disable_option_jumper);
endmodule // apdod_checker
bind apdod_top apdod_checker u_chk (.clk(clk), .reset_n(reset_n), .bus_sel(bus_sel),
	.bus_addr(bus_addr), .bus_page(bus_page), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
	.page_number_switch(page_number_switch), .command_output_disable(command_output_disable),
	.output_disable_option_jumper(output_disable_option_jumper), .fw_dout(fw_dout),
	.dig_out(dig_out));

// File: apdod_top_tb.sv
// Purpose: Self-checking bench for page decode and output gate
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Every bus hit queues a note; a monitor pops one per ack
`timescale 1ns/1ps
module apdod_top_tb;
	reg         clk, reset_n, bus_sel, bus_we, fw_we, stop_req, jumper;
	reg  [15:0] bus_addr;
	reg  [7:0]  bus_page, bus_wdata, fw_wdata, d1, d2;
	reg  [10:0] fw_addr;
	reg  [9:0]  o1, o2;
	reg  [3:0]  fw_dout;
	reg  [39:0] gray_pos;
	reg  [19:0] bin;
	reg  [1:0]  trk_a, trk_b, rp;
	reg  [7:0]  din;
	wire [31:0] enc_count;
	wire [1:0]  ref_seen;
	wire [7:0]  dig_in_sync;
	wire [39:0] abs_pos;
	wire [7:0]  bus_rdata, fw_rdata, sw;
	wire [3:0]  dig_out;
	wire        bus_ack, cod;
	integer     n_errors, cmp_count, cyc, i;
	reg  [8:0]  q[$];
	reg  [8:0]  e;
	apdod_top uut (.clk(clk), .reset_n(reset_n), .bus_sel(bus_sel), .bus_we(bus_we),
		.bus_addr(bus_addr), .bus_page(bus_page), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .bus_ack(bus_ack), .page_number_switch(sw),
		.command_output_disable(cod), .output_disable_option_jumper(jumper),
		.fw_we(fw_we), .fw_addr(fw_addr), .fw_wdata(fw_wdata), .fw_rdata(fw_rdata),
		.fw_dout(fw_dout), .dig_out(dig_out), .track_a(trk_a), .track_b(trk_b),
		.ref_pulse(rp), .gray_pos(gray_pos), .dig_in(din), .enc_count(enc_count),
		.ref_seen(ref_seen), .abs_pos(abs_pos), .dig_in_sync(dig_in_sync));
	apdod_ctrl_model ctl (.clk(clk), .stop_req(stop_req), .page_pair(7'h7F),
		.command_output_disable(cod), .page_number_switch(sw));
	task check(input [39:0] got, input [39:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task close_out;
		begin
			$display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
			if (n_errors == 0 && cmp_count > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task wt(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	// One bus cycle; hits note whether a read byte is due
	task bus(input we, input [15:0] a, input [7:0] p, input [7:0] d, input hit);
		begin
			wt(1);
			{bus_sel, bus_we, bus_addr, bus_page, bus_wdata} = {1'b1, we, a, p, d};
			if (hit)
				q.push_back({we, d});
		end
	endtask
	// One encoder state on axis one, held long enough to pass the synchronisers
	task qstep(input a, input b);
		begin
			trk_a[0] = a;
			trk_b[0] = b;
			wt(4);
		end
	endtask
	task fw(input we, input [10:0] a, input [7:0] d);
		begin
			wt(1);
			bus_sel = 0;
			{fw_we, fw_addr, fw_wdata} = {we, a, d};
			wt(1);
			fw_we = 0;
		end
	endtask
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	// Monitor: every ack takes the oldest note; hangs end the run
	always @(posedge clk) begin
		#2;
		cyc = cyc + 1;
		if (bus_ack === 1'b1) begin
			if (q.size() == 0)
				check(bus_ack, 0);
			else begin
				e = q.pop_front();
				if (!e[8])
					check(bus_rdata, e[7:0]);
			end
		end
		if (cyc > 3000) begin
			n_errors = n_errors + 1;
			close_out;
		end
	end
	initial begin
		n_errors = 0;
		cmp_count = 0;
		cyc = 0;
		{reset_n, bus_sel, bus_we, fw_we, stop_req, jumper} = 0;
		{bus_addr, bus_page, bus_wdata, fw_wdata, fw_addr, fw_dout, gray_pos} = 0;
		{trk_a, trk_b, rp, din} = 0;
		i = $urandom(37);
		{d1, d2, o1, o2} = {$urandom, $urandom};
		wt(4);
		reset_n = 1;
		wt(2);
		bus(1, 16'hF400 + o1, 8'hFE, d1, 1);
		bus(1, 16'hF400 + o2, 8'hFF, d2, 1);
		bus(0, 16'hF400 + o1, 8'hFE, d1, 1);
		bus(0, 16'hF400 + o2, 8'hFF, d2, 1);
		bus(1, 16'hF400 + o1, 8'hFD, ~d1, 0);
		bus(1, 16'hF400 + o1, 8'h00, ~d1, 0);
		bus(1, 16'hF3FF, 8'hFE, ~d1, 0);
		bus(1, 16'hF800, 8'hFF, ~d1, 0);
		fw(0, {1'b0, o1}, 8'h00);
		check(fw_rdata, d1);
		fw(0, {1'b1, o2}, 8'h00);
		check(fw_rdata, d2);
		fw(1, 11'h7FF, d1 ^ 8'h5A);
		bus(0, 16'hF7FF, 8'hFF, d1 ^ 8'h5A, 1);
		wt(1);
		bus_sel = 0;
		wt(4);
		check(q.size(), 0);
		$display("test pages done");
		fw_dout = 4'h1 + $urandom % 15;
		{jumper, stop_req} = 2'b11;
		wt(6);
		check(dig_out, 4'h0);
		stop_req = 0;
		wt(6);
		check(dig_out, fw_dout);
		{jumper, stop_req} = 2'b01;
		wt(8);
		check(dig_out, fw_dout);
		$display("test disable done");
		gray_pos = {$urandom, $urandom};
		bin[19] = gray_pos[19];
		for (i = 18; i >= 0; i = i - 1)
			bin[i] = bin[i + 1] ^ gray_pos[i];
		wt(6);
		check(abs_pos[19:0], bin);
		$display("test gray done");
		// A leads B for four steps, then B leads for two
		qstep(1, 0);
		qstep(1, 1);
		qstep(0, 1);
		qstep(0, 0);
		qstep(0, 1);
		qstep(1, 1);
		rp[0] = 1;
		din = $urandom;
		wt(4);
		rp[0] = 0;
		wt(4);
		check(enc_count[15:0], 16'h0002);
		check(enc_count[31:16], 16'h0000);
		check(ref_seen, 2'b01);
		check(dig_in_sync, din);
		$display("test encoder done");
		close_out;
	end
endmodule // apdod_top_tb
